// >>> verilog/dio_pkg.sv
// Purpose: Shared constants and types for the drive terminal I/O mapper
// Assumes: 25 MHz system clock, 12-bit analog samples, 16-bit settings
// Notes: Settings are plain ports; codes below are the selector encodings
package dio_pkg;
    localparam int ADC_W = 12;
    localparam int FREQ_W = 16;
    localparam int DAC_W = 12;
    localparam int PCT_W = 16;
    localparam logic [11:0] ADC_FULL = 12'hFFF;
    localparam logic [11:0] ADC_LOOP_LOW = 12'h333;
    localparam logic [11:0] DAC_FULL = 12'hFFF;
    localparam logic [11:0] DAC_OFFSET = 12'h333;
    localparam logic [15:0] PCT_UNITY = 16'h0064;
    localparam int FILT_W = 4;
    localparam int FILT_FRAC = 16;
    localparam int CLK_HZ = 25000000;
    localparam int DEBOUNCE_MS = 10;
    localparam int DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int DB_W = 18;
    // Out range selector
    localparam logic [1:0] OUT_RANGE_NONE = 2'h0;
    localparam logic [1:0] OUT_RANGE_ZERO = 2'h1;
    localparam logic [1:0] OUT_RANGE_OFFS = 2'h2;
    // Contact input function codes
    localparam logic [2:0] FN_NONE = 3'h0;
    localparam logic [2:0] FN_VREF = 3'h1;
    localparam logic [2:0] FN_IREF = 3'h2;
    localparam logic [2:0] FN_PRESET = 3'h3;
    localparam logic [2:0] FN_RAMP_DOWN = 3'h4;
    localparam logic [2:0] FN_RAMP_UP = 3'h5;
    localparam logic [2:0] FN_HAND = 3'h6;
    localparam logic [2:0] FN_REVERSE = 3'h7;
    // Fault contact modes
    localparam logic [1:0] FLT_NO_TRIP = 2'h0;
    localparam logic [1:0] FLT_NC_TRIP = 2'h1;
    localparam logic [1:0] FLT_CLEAR = 2'h2;
    typedef enum logic [2:0] {
        DIO_REF_DEFAULT = 3'b001,
        DIO_REF_VOLT = 3'b010,
        DIO_REF_CURR = 3'b100
    } dio_ref_e;
endpackage

// >>> verilog/dio_debounce.sv
// Purpose: Two-flop synchroniser and debounce for one contact input
// Assumes: Contact level is asynchronous to CLK
// Notes: Output changes only after the input holds steady for the count
`timescale 1ns/1ns
module dio_debounce #(
    parameter int COUNT = dio_pkg::DEBOUNCE_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic raw,
    output logic stable
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic level;
        logic [dio_pkg::DB_W-1:0] cnt;
    } dio_db_s;
    dio_db_s st;
    dio_db_s next_st;

    // Count while synchronised level differs from held level
    always_comb begin
        next_st = st;
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        if (st.s2 == st.level) begin
            next_st.cnt = '0;
        end else if (st.cnt >= dio_pkg::DB_W'(COUNT - 1)) begin
            next_st.level = st.s2;
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + dio_pkg::DB_W'(1);
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign stable = st.level;
endmodule

// >>> verilog/dio_mapper.sv
// Purpose: Terminal I/O of a motor drive: reference scaling, filters,
//          analog outputs, contact functions and the fault contact
// Assumes: Digitized analog samples every clock; contacts closed = 1
// Notes:
// Notes on behaviour
// - Full-scale reference gives the high-frequency setting, linear in between.
// - Bottom of reference range gives the low-frequency setting.
// - Low above high gives inverse scaling; no clamp or ordering check.
// - One adjustable filter for both inputs; higher setting responds slower.
// - Frequency output proportional to frequency; zero, offset span or disabled.
// - Frequency output full scale exactly at the frequency full-scale setting.
// - Load output proportional to load; zero-based or offset span.
// - Load output full scale at the load full-scale percentage.
// - Load output uses load after the ratio scaling, not raw load.
// - Active voltage or current function selects that channel as reference.
// - Input A acts on closure: none, volt, current, preset, down, reverse.
// - Input B acts on closure: none, volt, current, preset, ramp up.
// - Input C acts on closure: none, volt, current, preset, hand, reverse.
// - Hand start on C is permitted only while the run contact is closed too.
// - With bypass fitted, input C is fixed at hand mode.
// - Normally-open mode trips external fault on contact closure.
// - Normally-closed mode trips external fault on contact opening.
// - Clear mode: closure clears fault; run contact no longer clears; stop does.
`timescale 1ns/1ns
module dio_mapper #(
    parameter int DEBOUNCE = dio_pkg::DEBOUNCE_CYC
) (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic [11:0] VOLTAGE_REF_INPUT,
    input wire logic [11:0] CURRENT_REF_INPUT,
    input wire logic [15:0] REF_LOW_FREQ_SETTING,
    input wire logic [15:0] REF_HIGH_FREQ_SETTING,
    input wire logic [3:0] ANALOG_IN_FILTER_SETTING,
    input wire logic [15:0] OUTPUT_FREQ,
    input wire logic [1:0] FREQ_OUT_RANGE_SELECT,
    input wire logic [15:0] FREQ_OUT_FULL_SCALE,
    input wire logic [15:0] DRIVE_LOAD,
    input wire logic [1:0] LOAD_OUT_RANGE_SELECT,
    input wire logic [15:0] LOAD_OUT_FULL_SCALE,
    input wire logic [15:0] LOAD_RATIO_SCALE,
    input wire logic [2:0] CONTACT_A_FUNCTION,
    input wire logic [2:0] CONTACT_B_FUNCTION,
    input wire logic [2:0] CONTACT_C_FUNCTION,
    input wire logic [1:0] FAULT_CONTACT_MODE,
    input wire logic BYPASS_FITTED,
    input wire logic CONTACT_INPUT_A,
    input wire logic CONTACT_INPUT_B,
    input wire logic CONTACT_INPUT_C,
    input wire logic FAULT_CONTACT_INPUT,
    input wire logic RUN_CONTACT,
    input wire logic STOP_KEY,
    input wire logic FAULT_ACTIVE,
    output logic [15:0] REF_FREQ,
    output logic REF_FROM_VOLTAGE,
    output logic REF_FROM_CURRENT,
    output logic [11:0] VOLTAGE_FILTERED,
    output logic [11:0] CURRENT_FILTERED,
    output logic PRESET_SEL_1,
    output logic PRESET_SEL_2,
    output logic PRESET_SEL_3,
    output logic RAMP_DOWN_FREQ,
    output logic RAMP_UP_FREQ,
    output logic REVERSE_ROTATION,
    output logic HAND_MODE,
    output logic HAND_START_PERMIT,
    output logic EXTERNAL_FAULT,
    output logic FAULT_CLEAR,
    output logic [11:0] FREQ_ANALOG_OUTPUT,
    output logic FREQ_ANALOG_ENABLE,
    output logic [11:0] LOAD_ANALOG_OUTPUT
);
    localparam int ACC_W = 12 + dio_pkg::FILT_FRAC;

    typedef struct packed {
        logic [ACC_W-1:0] v_acc;
        logic [ACC_W-1:0] i_acc;
        dio_pkg::dio_ref_e ref_src;
        logic [15:0] ref_freq;
        logic [11:0] freq_out;
        logic freq_en;
        logic [11:0] load_out;
        logic pre1;
        logic pre2;
        logic pre3;
        logic rdown;
        logic rup;
        logic rev;
        logic hand;
        logic hand_ok;
        logic ext_fault;
        logic flt_clear;
        logic fc_prev;
    } dio_state_s;

    dio_state_s st;
    dio_state_s next_st;

    // Debounced contacts: A, B, C, fault, run
    logic [4:0] raw_in;
    logic [4:0] deb;

    assign raw_in = {RUN_CONTACT, FAULT_CONTACT_INPUT, CONTACT_INPUT_C,
                     CONTACT_INPUT_B, CONTACT_INPUT_A};

    // One synchroniser and debouncer per contact
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_db
            dio_debounce #(.COUNT(DEBOUNCE)) u_db (
                .CLK(CLK),
                .SRST(SRST),
                .raw(raw_in[gi]),
                .stable(deb[gi])
            );
        end
    endgenerate

    logic ca;
    logic cb;
    logic cc;
    logic cflt;
    logic crun;
    logic [2:0] fn_c;

    assign ca = deb[0];
    assign cb = deb[1];
    assign cc = deb[2];
    assign cflt = deb[3];
    assign crun = deb[4];
    assign fn_c = BYPASS_FITTED ? dio_pkg::FN_HAND : CONTACT_C_FUNCTION;

    // Combinational helpers for scaling
    logic [11:0] v_filt;
    logic [11:0] i_filt;
    logic [4:0] filt_sh;
    logic [11:0] span_pos;
    logic [11:0] span_len;
    logic signed [17:0] fdiff;
    logic signed [31:0] fprod;
    logic signed [17:0] fref;
    logic [31:0] f_num;
    logic [31:0] f_q;
    logic [31:0] load_scaled;
    logic [31:0] l_num;
    logic [31:0] l_q;
    logic [11:0] f_raw;
    logic [11:0] l_raw;
    logic [11:0] f_dac;
    logic [11:0] l_dac;
    logic want_v;
    logic want_i;

    assign v_filt = st.v_acc[ACC_W-1 -: 12];
    assign i_filt = st.i_acc[ACC_W-1 -: 12];
    // Filter shift one bit wider so the top setting cannot wrap to zero
    assign filt_sh = {1'b0, ANALOG_IN_FILTER_SETTING} + 5'h01;

    // Raw fraction of full scale clipped to 12 bits
    function automatic logic [11:0] clip12(input logic [31:0] q);
        clip12 = (q > 32'(dio_pkg::DAC_FULL)) ? dio_pkg::DAC_FULL : q[11:0];
    endfunction

    // Place fraction in zero-based or offset span
    function automatic logic [11:0] span(input logic [11:0] f, input logic [1:0] rsel);
        logic [23:0] p;
        p = 24'(f) * 24'(dio_pkg::DAC_FULL - dio_pkg::DAC_OFFSET);
        if (rsel == dio_pkg::OUT_RANGE_OFFS) begin
            span = dio_pkg::DAC_OFFSET + 12'(p / 24'(dio_pkg::DAC_FULL));
        end else begin
            span = f;
        end
    endfunction

    always_comb begin
        // Channel chosen by active contact functions
        want_v = (ca && CONTACT_A_FUNCTION == dio_pkg::FN_VREF)
              || (cb && CONTACT_B_FUNCTION == dio_pkg::FN_VREF)
              || (cc && fn_c == dio_pkg::FN_VREF);
        want_i = (ca && CONTACT_A_FUNCTION == dio_pkg::FN_IREF)
              || (cb && CONTACT_B_FUNCTION == dio_pkg::FN_IREF)
              || (cc && fn_c == dio_pkg::FN_IREF);
        // Current loop bottom maps to the low setting
        if (st.ref_src == dio_pkg::DIO_REF_CURR) begin
            span_pos = (i_filt > dio_pkg::ADC_LOOP_LOW) ? i_filt - dio_pkg::ADC_LOOP_LOW
                                                       : 12'h000;
            span_len = dio_pkg::ADC_FULL - dio_pkg::ADC_LOOP_LOW;
        end else begin
            span_pos = v_filt;
            span_len = dio_pkg::ADC_FULL;
        end
        // Signed interpolation keeps inverse scaling working
        fdiff = 18'(signed'({2'b00, REF_HIGH_FREQ_SETTING}))
              - 18'(signed'({2'b00, REF_LOW_FREQ_SETTING}));
        fprod = 32'(fdiff) * 32'(signed'({20'h00000, span_pos}));
        fref = 18'(signed'({2'b00, REF_LOW_FREQ_SETTING}))
             + 18'(fprod / 32'(signed'({20'h00000, span_len})));
        // Frequency output fraction
        f_num = 32'(OUTPUT_FREQ) * 32'(dio_pkg::DAC_FULL);
        f_q = (FREQ_OUT_FULL_SCALE == 16'h0000) ? 32'(dio_pkg::DAC_FULL)
                                                : f_num / 32'(FREQ_OUT_FULL_SCALE);
        f_raw = clip12(f_q);
        f_dac = span(f_raw, FREQ_OUT_RANGE_SELECT);
        // Load after ratio scaling
        load_scaled = 32'(DRIVE_LOAD) * 32'(LOAD_RATIO_SCALE) / 32'(dio_pkg::PCT_UNITY);
        l_num = 32'(load_scaled[19:0]) * 32'(dio_pkg::DAC_FULL);
        if (load_scaled > 32'h000FFFFF) begin
            l_q = 32'(dio_pkg::DAC_FULL);
        end else if (LOAD_OUT_FULL_SCALE == 16'h0000) begin
            l_q = 32'(dio_pkg::DAC_FULL);
        end else begin
            l_q = l_num / 32'(LOAD_OUT_FULL_SCALE);
        end
        l_raw = clip12(l_q);
        l_dac = span(l_raw, LOAD_OUT_RANGE_SELECT);

        next_st = st;
        // First-order low-pass, shift sets the time constant
        next_st.v_acc = st.v_acc + ACC_W'((signed'({1'b0, VOLTAGE_REF_INPUT, 16'h0000})
                        - signed'({1'b0, st.v_acc})) >>> filt_sh);
        next_st.i_acc = st.i_acc + ACC_W'((signed'({1'b0, CURRENT_REF_INPUT, 16'h0000})
                        - signed'({1'b0, st.i_acc})) >>> filt_sh);
        if (want_v) begin
            next_st.ref_src = dio_pkg::DIO_REF_VOLT;
        end else if (want_i) begin
            next_st.ref_src = dio_pkg::DIO_REF_CURR;
        end else begin
            next_st.ref_src = dio_pkg::DIO_REF_DEFAULT;
        end
        next_st.ref_freq = (fref < 0) ? 16'h0000
                         : (fref > 18'sh0FFFF) ? 16'hFFFF : fref[15:0];
        next_st.freq_en = (FREQ_OUT_RANGE_SELECT != dio_pkg::OUT_RANGE_NONE);
        next_st.freq_out = next_st.freq_en ? f_dac : 12'h000;
        next_st.load_out = l_dac;
        // Contact functions
        next_st.pre1 = ca && CONTACT_A_FUNCTION == dio_pkg::FN_PRESET;
        next_st.rdown = ca && CONTACT_A_FUNCTION == dio_pkg::FN_RAMP_DOWN;
        next_st.pre2 = cb && CONTACT_B_FUNCTION == dio_pkg::FN_PRESET;
        next_st.rup = cb && CONTACT_B_FUNCTION == dio_pkg::FN_RAMP_UP;
        next_st.pre3 = cc && fn_c == dio_pkg::FN_PRESET;
        next_st.hand = cc && fn_c == dio_pkg::FN_HAND;
        next_st.rev = (ca && CONTACT_A_FUNCTION == dio_pkg::FN_REVERSE)
                   || (cc && fn_c == dio_pkg::FN_REVERSE);
        next_st.hand_ok = next_st.hand && crun;
        // External fault contact
        next_st.fc_prev = cflt;
        case (FAULT_CONTACT_MODE)
            dio_pkg::FLT_NO_TRIP: begin
                next_st.ext_fault = cflt;
                next_st.flt_clear = STOP_KEY || (crun && !st.hand);
            end
            dio_pkg::FLT_NC_TRIP: begin
                next_st.ext_fault = !cflt;
                next_st.flt_clear = STOP_KEY || (crun && !st.hand);
            end
            dio_pkg::FLT_CLEAR: begin
                next_st.ext_fault = 1'b0;
                next_st.flt_clear = STOP_KEY || (cflt && !st.fc_prev);
            end
            default: begin
                next_st.ext_fault = 1'b0;
                next_st.flt_clear = STOP_KEY;
            end
        endcase
        next_st.flt_clear = next_st.flt_clear && FAULT_ACTIVE;
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            st <= '0;
            st.ref_src <= dio_pkg::DIO_REF_DEFAULT;
        end else begin
            st <= next_st;
        end
    end

    assign REF_FREQ = st.ref_freq;
    assign REF_FROM_VOLTAGE = st.ref_src == dio_pkg::DIO_REF_VOLT;
    assign REF_FROM_CURRENT = st.ref_src == dio_pkg::DIO_REF_CURR;
    assign VOLTAGE_FILTERED = v_filt;
    assign CURRENT_FILTERED = i_filt;
    assign PRESET_SEL_1 = st.pre1;
    assign PRESET_SEL_2 = st.pre2;
    assign PRESET_SEL_3 = st.pre3;
    assign RAMP_DOWN_FREQ = st.rdown;
    assign RAMP_UP_FREQ = st.rup;
    assign REVERSE_ROTATION = st.rev;
    assign HAND_MODE = st.hand;
    assign HAND_START_PERMIT = st.hand_ok;
    assign EXTERNAL_FAULT = st.ext_fault;
    assign FAULT_CLEAR = st.flt_clear;
    assign FREQ_ANALOG_OUTPUT = st.freq_out;
    assign FREQ_ANALOG_ENABLE = st.freq_en;
    assign LOAD_ANALOG_OUTPUT = st.load_out;

    // Checks
    sequence s_fault_closed;
        deb[3] && FAULT_CONTACT_MODE == dio_pkg::FLT_NO_TRIP;
    endsequence
    sequence s_fault_open;
        !deb[3] && FAULT_CONTACT_MODE == dio_pkg::FLT_NC_TRIP;
    endsequence

    AST_NO_TRIP: assert property (@(posedge CLK) disable iff (SRST)
        s_fault_closed |=> EXTERNAL_FAULT)
        else $error("closed fault contact did not trip");
    AST_NC_TRIP: assert property (@(posedge CLK) disable iff (SRST)
        s_fault_open |=> EXTERNAL_FAULT)
        else $error("open fault contact did not trip");
    AST_CLEAR_NO_TRIP: assert property (@(posedge CLK) disable iff (SRST)
        FAULT_CONTACT_MODE == dio_pkg::FLT_CLEAR |=> !EXTERNAL_FAULT)
        else $error("clear mode tripped");
    AST_RUN_NO_CLEAR: assert property (@(posedge CLK) disable iff (SRST)
        FAULT_CONTACT_MODE == dio_pkg::FLT_CLEAR && !STOP_KEY && !deb[3]
        |=> !FAULT_CLEAR)
        else $error("fault cleared without contact");
    AST_HAND_RUN: assert property (@(posedge CLK) disable iff (SRST)
        HAND_START_PERMIT |-> HAND_MODE && $past(deb[4]))
        else $error("hand start without run contact");
    AST_BYPASS: assert property (@(posedge CLK) disable iff (SRST)
        BYPASS_FITTED && deb[2] |=> HAND_MODE && !PRESET_SEL_3)
        else $error("bypass did not force hand");
    AST_FREQ_OFF: assert property (@(posedge CLK) disable iff (SRST)
        FREQ_OUT_RANGE_SELECT == dio_pkg::OUT_RANGE_NONE |=> FREQ_ANALOG_OUTPUT == 12'h000)
        else $error("disabled output not zero");
    AST_FREQ_FULL: assert property (@(posedge CLK) disable iff (SRST)
        FREQ_OUT_RANGE_SELECT != dio_pkg::OUT_RANGE_NONE
        && OUTPUT_FREQ == FREQ_OUT_FULL_SCALE |=> FREQ_ANALOG_OUTPUT == dio_pkg::DAC_FULL)
        else $error("frequency output not full at scale");
    AST_OFFSET_FLOOR: assert property (@(posedge CLK) disable iff (SRST)
        LOAD_OUT_RANGE_SELECT == dio_pkg::OUT_RANGE_OFFS
        |=> LOAD_ANALOG_OUTPUT >= dio_pkg::DAC_OFFSET)
        else $error("offset load output below floor");
    AST_VREF: assert property (@(posedge CLK) disable iff (SRST)
        deb[0] && CONTACT_A_FUNCTION == dio_pkg::FN_VREF |=> REF_FROM_VOLTAGE)
        else $error("voltage reference not selected");
endmodule

// >>> dv/dio_field.sv
// Purpose: Field wiring model: operator contacts, run contact and fault contact
// Assumes: Bit 0..2 inputs A..C, bit 3 fault contact, bit 4 run contact
// Notes: With chatter on, a change flips back and forth before it settles
`timescale 1ns/1ns
module dio_field (
    input wire logic CLK,
    input wire logic [4:0] want,
    input wire logic chatter,
    output logic [4:0] pins
);
    logic [4:0] last = 5'h00;
    int n = 0;
    initial pins = 5'h00;
    // Contacts follow the operator; run and hand contacts are closed as asked
    always @(posedge CLK) begin
        if (chatter && want != last && n < 3) begin
            pins <= pins ^ (want ^ last);
            n <= n + 1;
        end else begin
            pins <= want;
            last <= want;
            n <= 0;
        end
    end
endmodule

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the drive terminal I/O mapper
// Assumes: Debounce shortened to 4 cycles; inputs change on the falling edge
// Notes: The driver queues expected values; a monitor compares them when due
`timescale 1ns/1ns
module testbench;
    typedef struct {int sel; int exp; int tol; int due;} dio_note_s;
    localparam int DB = 4;
    localparam int AF = int'(dio_pkg::ADC_FULL);
    localparam int LL = int'(dio_pkg::ADC_LOOP_LOW);
    localparam int DF = int'(dio_pkg::DAC_FULL);
    localparam int DO = int'(dio_pkg::DAC_OFFSET);
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] vin = 12'h000, cin = 12'h000;
    logic [15:0] low = 16'h0000, high = 16'h0258, ofreq = 16'h0000, ffs = 16'h0258;
    logic [15:0] load = 16'h0000, lfs = 16'h0078, lratio = 16'h0096;
    logic [3:0] filt = 4'h0;
    logic [1:0] frng = 2'h1, lrng = 2'h1, fmode = 2'h0;
    logic [2:0] fa = 3'h0, fb = 3'h0, fc = 3'h0;
    logic bypass = 1'b0, stop = 1'b0, factive = 1'b0, chatter = 1'b0;
    logic [4:0] want = 5'h00, pins;
    logic [15:0] ref_freq, v;
    logic [11:0] vflt, cflt, fao, lao;
    logic from_v, from_c, p1, p2, p3, dn, up, rev, hand, permit, ext_flt, fclr, fae;
    int cyc = 0, clr_cnt = 0, error_cnt = 0, checked = 0;
    int seed = 32'hA0F51556;
    int lo_t[3] = '{0, 100, 600};
    int hi_t[3] = '{600, 600, 100};
    int f_t[4] = '{0, 300, 600, 1200};
    string nm[10] = '{"REF_FREQ", "VOLTAGE_FILTERED", "CURRENT_FILTERED", "FREQ_ANALOG_OUTPUT",
        "FREQ_ANALOG_ENABLE", "LOAD_ANALOG_OUTPUT", "functions", "EXTERNAL_FAULT",
        "clear pulses", "FAULT_CLEAR"};
    dio_note_s notes[$];
    dio_note_s mn;

    dio_field u_field (.CLK(clk), .want(want), .chatter(chatter), .pins(pins));

    dio_mapper #(.DEBOUNCE(DB)) u_dut (
        .CLK(clk), .SRST(srst), .VOLTAGE_REF_INPUT(vin), .CURRENT_REF_INPUT(cin),
        .REF_LOW_FREQ_SETTING(low), .REF_HIGH_FREQ_SETTING(high),
        .ANALOG_IN_FILTER_SETTING(filt), .OUTPUT_FREQ(ofreq), .FREQ_OUT_RANGE_SELECT(frng),
        .FREQ_OUT_FULL_SCALE(ffs), .DRIVE_LOAD(load), .LOAD_OUT_RANGE_SELECT(lrng),
        .LOAD_OUT_FULL_SCALE(lfs), .LOAD_RATIO_SCALE(lratio), .CONTACT_A_FUNCTION(fa),
        .CONTACT_B_FUNCTION(fb), .CONTACT_C_FUNCTION(fc), .FAULT_CONTACT_MODE(fmode),
        .BYPASS_FITTED(bypass), .CONTACT_INPUT_A(pins[0]), .CONTACT_INPUT_B(pins[1]),
        .CONTACT_INPUT_C(pins[2]), .FAULT_CONTACT_INPUT(pins[3]), .RUN_CONTACT(pins[4]),
        .STOP_KEY(stop), .FAULT_ACTIVE(factive), .REF_FREQ(ref_freq),
        .REF_FROM_VOLTAGE(from_v), .REF_FROM_CURRENT(from_c), .VOLTAGE_FILTERED(vflt),
        .CURRENT_FILTERED(cflt), .PRESET_SEL_1(p1), .PRESET_SEL_2(p2), .PRESET_SEL_3(p3),
        .RAMP_DOWN_FREQ(dn), .RAMP_UP_FREQ(up), .REVERSE_ROTATION(rev), .HAND_MODE(hand),
        .HAND_START_PERMIT(permit), .EXTERNAL_FAULT(ext_flt), .FAULT_CLEAR(fclr),
        .FREQ_ANALOG_OUTPUT(fao), .FREQ_ANALOG_ENABLE(fae), .LOAD_ANALOG_OUTPUT(lao));

    // Clock, 40 ns period
    always #20 clk = ~clk;

    // Observed value by selector
    function automatic logic [15:0] get(input int sel);
        case (sel)
            0: get = ref_freq;
            1: get = {4'h0, vflt};
            2: get = {4'h0, cflt};
            3: get = {4'h0, fao};
            4: get = {15'h0000, fae};
            5: get = {4'h0, lao};
            6: get = {6'h00, p1, p2, p3, dn, up, rev, hand, permit, from_v, from_c};
            7: get = {15'h0000, ext_flt};
            8: get = clr_cnt[15:0];
            default: get = {15'h0000, fclr};
        endcase
    endfunction

    // Expected function vector for input k with code c
    function automatic int fvec(input int k, input int c);
        case (c)
            1: return 2;
            2: return 1;
            3: return 512 >> k;
            4: return 64;
            5: return 32;
            6: return 8;
            7: return 16;
            default: return 0;
        endcase
    endfunction

    // Linear reference mapping from range bottom b to full scale
    function automatic int ref_exp(input int lo, input int hi, input int x, input int b);
        return lo + (hi - lo) * (x - b) / (AF - b);
    endfunction

    // Analog output code for range r, value x, full-scale setting fs
    function automatic int out_exp(input int r, input int x, input int fs);
        int e;
        if (r == 0) return 0;
        e = (fs == 0) ? DF : x * DF / fs;
        if (e > DF) e = DF;
        if (r == 2) e = DO + e * (DF - DO) / DF;
        return e;
    endfunction

    // Queue an expectation due after dly cycles and let time pass
    task automatic chk(input int sel, input int exp, input int tol, input int dly);
        notes.push_back('{sel, exp, tol, cyc + dly});
        repeat (dly + 1) @(negedge clk);
    endtask

    // Monitor: counts clear pulses and compares due notes
    always @(posedge clk) begin
        #5;
        cyc++;
        if (fclr === 1'b1) clr_cnt++;
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            mn = notes.pop_front();
            v = get(mn.sel);
            checked++;
            if ($isunknown(v) || (int'(v) > mn.exp ? int'(v) - mn.exp : mn.exp - int'(v)) > mn.tol) begin
                error_cnt++;
                $display("unexpected %s: expected %0d, seen %0d", nm[mn.sel], mn.exp, v);
            end
        end
    end

    task automatic test_done;
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #(40 * 20000);
        error_cnt++;
        test_done;
    end

    // Main sequence
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        chk(0, 0, 0, 0);
        chk(6, 0, 0, 0);
        // Voltage reference mapping, plain and inverse
        for (int i = 0; i < 9; i++) begin
            low = 16'(lo_t[i / 3]);
            high = 16'(hi_t[i / 3]);
            vin = (i % 3 == 0) ? 12'h000 : (i % 3 == 1) ? 12'hFFF : 12'($random(seed));
            chk(0, ref_exp(low, high, vin, 0), (high > low ? high - low : low - high) / 2048 + 2, 60);
            chk(1, vin, 1, 0);
        end
        // Current reference selected by a contact
        fa = dio_pkg::FN_IREF;
        want[0] = 1'b1;
        chk(6, 1, 0, 20);
        cin = 12'h333;
        chk(0, ref_exp(low, high, cin, LL), 2, 60);
        cin = 12'hFFF;
        chk(0, ref_exp(low, high, cin, LL), 2, 60);
        // Filter speed on both channels
        vin = 12'h000;
        cin = 12'h000;
        repeat (60) @(negedge clk);
        filt = 4'h8;
        vin = 12'hFFF;
        cin = 12'hFFF;
        chk(1, 0, 255, 8);
        chk(2, 0, 255, 0);
        filt = 4'h0;
        vin = 12'h000;
        cin = 12'h000;
        repeat (60) @(negedge clk);
        vin = 12'hFFF;
        cin = 12'hFFF;
        chk(1, AF, 511, 8);
        chk(2, AF, 511, 0);
        want[0] = 1'b0;
        // Frequency output, every range, saturation included
        for (int r = 0; r < 3; r++) begin
            for (int j = 0; j < 5; j++) begin
                frng = 2'(r);
                ofreq = (j == 4) ? 16'($unsigned($random(seed)) % 600) : 16'(f_t[j]);
                chk(3, out_exp(r, ofreq, ffs), 2, 3);
                chk(4, (r != 0), 0, 0);
            end
        end
        // Load output after ratio scaling
        for (int r = 1; r < 3; r++) begin
            for (int j = 0; j < 3; j++) begin
                lrng = 2'(r);
                load = (j == 0) ? 16'h0050 : (j == 1) ? 16'h0028 : 16'($unsigned($random(seed)) % 80);
                chk(5, out_exp(r, load * lratio / 100, lfs), 2, 3);
            end
        end
        // Every legal function of contacts A, B and C
        for (int k = 0; k < 3; k++) begin
            for (int c = 0; c < 8; c++) begin
                if ((k == 0 && (c == 5 || c == 6)) || (k == 1 && (c == 4 || c > 5))
                    || (k == 2 && (c == 4 || c == 5))) continue;
                fa = (k == 0) ? 3'(c) : dio_pkg::FN_NONE;
                fb = (k == 1) ? 3'(c) : dio_pkg::FN_NONE;
                fc = (k == 2) ? 3'(c) : dio_pkg::FN_NONE;
                want[k] = 1'b1;
                chk(6, fvec(k, c), 0, 20);
                want[k] = 1'b0;
                chk(6, 0, 0, 20);
            end
        end
        // Hand mode start permit, with chattering contacts
        fc = dio_pkg::FN_HAND;
        chatter = 1'b1;
        want[2] = 1'b1;
        chk(6, 8, 0, 20);
        want[4] = 1'b1;
        chk(6, 12, 0, 20);
        want = 5'h00;
        chk(6, 0, 0, 20);
        // Bypass fixes C at hand
        fc = dio_pkg::FN_REVERSE;
        bypass = 1'b1;
        want[2] = 1'b1;
        chk(6, 8, 0, 20);
        bypass = 1'b0;
        chatter = 1'b0;
        // Short glitch is ignored
        fc = dio_pkg::FN_NONE;
        fa = dio_pkg::FN_PRESET;
        want = 5'h01;
        repeat (2) @(negedge clk);
        want = 5'h00;
        chk(6, 0, 0, 20);
        // External fault, normally open then normally closed
        fmode = dio_pkg::FLT_NO_TRIP;
        want[3] = 1'b1;
        chk(7, 1, 0, 20);
        want[3] = 1'b0;
        chk(7, 0, 0, 20);
        fmode = dio_pkg::FLT_NC_TRIP;
        chk(7, 1, 0, 20);
        want[3] = 1'b1;
        chk(7, 0, 0, 20);
        // Fault clear sources
        want = 5'h10;
        fmode = dio_pkg::FLT_NO_TRIP;
        factive = 1'b1;
        chk(9, 1, 0, 20);
        fmode = dio_pkg::FLT_CLEAR;
        chk(9, 0, 0, 2);
        clr_cnt = 0;
        want[3] = 1'b1;
        chk(8, 1, 0, 20);
        clr_cnt = 0;
        stop = 1'b1;
        repeat (5) @(negedge clk);
        stop = 1'b0;
        chk(8, 5, 0, 5);
        repeat (2) @(negedge clk);
        test_done;
    end
endmodule
